/* File: hw/input_sync.sv */
/*
 Two-stage synchroniser with edge detection for a group of input pins.
 Assumes pins are slow against the clock and may change at any time.
*/
`timescale 1ns/10ps
module input_sync #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Pins and results
	input  wire logic [WIDTH-1:0] pins_in,
	output logic      [WIDTH-1:0] level_out,
	output logic      [WIDTH-1:0] rise_out,
	output logic      [WIDTH-1:0] fall_out
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] stable;

	// First stage is read only by the second stage
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta   <= '0;
			stable <= '0;
		end else begin
			meta   <= pins_in;
			stable <= meta;
		end
	end

	// Delayed copy for edge detection
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			level_out <= '0;
		end else begin
			level_out <= stable;
		end
	end

	assign rise_out = stable & ~level_out;
	assign fall_out = ~stable & level_out;
endmodule

/* File: hw/lic_defs.svh */
/*
 Constants for the local input counter and encoder block: register offsets,
 field positions, reset values and timing figures.
 Assumes inclusion by bare name from any design file.
*/
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH

// Register word offsets (byte addresses, one aligned word each)
`define REG_CTRL        8'h00
`define REG_SETPOINT    8'h04
`define REG_COUNT       8'h08
`define REG_STATUS      8'h0c
`define REG_MASK        8'h10
`define REG_INPUTS      8'h14

// Control register fields
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   2
`define CTRL_EDGE4      3
`define CTRL_EDGE5      4
`define CTRL_CLEAR      5
`define CTRL_RESET      32'h0000_0000

// Status and mask bit positions
`define ST_SETPOINT_LO  0
`define ST_SETPOINT_HI  1
`define ST_IRQ4         2
`define ST_IRQ5         3
`define ST_REFERENCE    4
`define ST_WIDTH        5

// Timing: track rate limit and clock rate
`define TRACK_MAX_KHZ   50
`define CLOCK_KHZ       125000
`define EDGE_SPACING_CYCLES ((`CLOCK_KHZ) / (4 * `TRACK_MAX_KHZ))

`endif

/* File: hw/lic_pkg.sv */
/*
 Types shared by the local input counter design files.
 Assumes the defs header for all numeric constants.
*/
package lic_pkg;
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_ENCODER,
		MODE_COUNT32,
		MODE_COUNT16,
		MODE_IRQ_ONLY
	} mode_type;
endpackage

/* File: hw/local_input_counter_encoder.sv */
/*
 Local input preprocessing: quadrature encoder, 32-bit or dual 16-bit
 up/down counters with setpoint, and two edge interrupt inputs.
 Assumes inputs asynchronous level signals from field wiring, a plain
 register port with one-cycle strobes, and a single clock.
*/
// Decided for this implementation: the plain strobed port and the register addresses.
//
// Contract
// R01: Six inputs, function chosen by mode
// R02: One encoder: tracks on 0,1, reference 2
// R03: Direction from track phase relation
// R04: Count all edges of both tracks
// R05: Fourfold edge rate at 50 kHz handled
// R06: Reference acts only while window closed
// R07: Counter pulse input up to 50 kHz
// R08: Direction level picks up or down
// R09: Source keeps direction stable before pulses
// R10: Setpoint reached raises interrupt
// R11: Up count restarts at zero after setpoint
// R12: Down count reloads setpoint after setpoint
// R13: Two 16-bit counters on inputs 0-1, 2-3
// R14: Inputs 4,5 interrupt on chosen edge
// R15: Inputs pass two flip-flops first
// R16: Events held as sticky pending flags
`timescale 1ns/10ps
`include "lic_defs.svh"
module local_input_counter_encoder #(
	parameter int COUNT_WIDTH = 32
) (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// Local inputs
	input  wire logic        local_in_zero_track_a_pulse_in,
	input  wire logic        local_in_one_track_b_direction_in,
	input  wire logic        local_in_two_reference_pulse_in,
	input  wire logic        local_in_three_ref_window_in,
	input  wire logic        local_in_four_irq_in,
	input  wire logic        local_in_five_irq_in,
	// Register port
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	// Interrupt
	output logic             irq_out
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisation
	logic [5:0] pins;
	logic [5:0] lvl;
	logic [5:0] rise;
	logic [5:0] fall;

	assign pins = {local_in_five_irq_in, local_in_four_irq_in, local_in_three_ref_window_in,
	               local_in_two_reference_pulse_in, local_in_one_track_b_direction_in,
	               local_in_zero_track_a_pulse_in};

	// Two stages then edge detect, see R15
	input_sync #(
		.WIDTH (6)
	) sync_u (
		.clk_in    (mclk_in),
		.rst_in    (rst_in),
		.pins_in   (pins),
		.level_out (lvl),
		.rise_out  (rise),
		.fall_out  (fall)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0]                ctrl;
	logic [COUNT_WIDTH-1:0]     setpoint;
	logic [COUNT_WIDTH-1:0]     count;
	logic [`ST_WIDTH-1:0]       status;
	logic [`ST_WIDTH-1:0]       mask;
	lic_pkg::mode_type          mode;

	// Mode field decode, see R01
	always_comb begin
		case (ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB])
			3'h1:    mode = lic_pkg::MODE_ENCODER;
			3'h2:    mode = lic_pkg::MODE_COUNT32;
			3'h3:    mode = lic_pkg::MODE_COUNT16;
			3'h4:    mode = lic_pkg::MODE_IRQ_ONLY;
			default: mode = lic_pkg::MODE_OFF;
		endcase
	end

	logic wr_ctrl;
	logic wr_status;
	assign wr_ctrl   = wr_in && (addr_in == `REG_CTRL);
	assign wr_status = wr_in && (addr_in == `REG_STATUS);

	// Control, setpoint and mask storage; clear bit is self-clearing
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl     <= `CTRL_RESET;
			setpoint <= '0;
			mask     <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= wdata_in;
			end else begin
				ctrl[`CTRL_CLEAR] <= 1'b0;
			end
			if (wr_in && addr_in == `REG_SETPOINT) begin
				setpoint <= wdata_in[COUNT_WIDTH-1:0];
			end
			if (wr_in && addr_in == `REG_MASK) begin
				mask <= wdata_in[`ST_WIDTH-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Quadrature decode
	logic enc_step;
	logic enc_up;
	logic enc_ref;

	// Any track edge is one count, see R04
	assign enc_step = rise[0] | fall[0] | rise[1] | fall[1];
	// A leading B counts up, see R03
	assign enc_up   = (rise[0] | fall[0]) ? (lvl[0] ^ lvl[1]) ^ 1'b1 : (lvl[0] ^ lvl[1]);
	// Reference gated by window switch, see R02 see R06
	assign enc_ref  = rise[2] & lvl[3];

	////////////////////////////////////////////////////////////////////////
	// Counter step functions
	function automatic logic [15:0] step16(input logic [15:0] v, input logic up, input logic [15:0] sp);
		logic [15:0] r;
		r = v;
		if (v == sp) begin
			r = up ? 16'h0000 : sp; // see R11 see R12
		end else begin
			r = up ? v + 16'h0001 : v - 16'h0001;
		end
		return r;
	endfunction

	function automatic logic [31:0] step32(input logic [31:0] v, input logic up, input logic [31:0] sp);
		logic [31:0] r;
		r = v;
		if (v == sp) begin
			r = up ? 32'h0000_0000 : sp; // see R11 see R12
		end else begin
			r = up ? v + 32'h0000_0001 : v - 32'h0000_0001;
		end
		return r;
	endfunction

	// Pulse on rising edge, direction is the live level, see R07 see R08 see R13
	logic lo_pulse;
	logic hi_pulse;
	logic lo_up;
	logic hi_up;
	assign lo_pulse = rise[0];
	assign lo_up    = lvl[1];
	assign hi_pulse = rise[2];
	assign hi_up    = lvl[3];

	logic [31:0] next_count;
	logic        hit_lo;
	logic        hit_hi;

	// Next count per mode; one clock per edge covers 200 kHz, see R05
	always_comb begin
		next_count = count;
		hit_lo     = 1'b0;
		hit_hi     = 1'b0;
		case (mode)
			lic_pkg::MODE_ENCODER: begin
				if (enc_ref) begin
					next_count = 32'h0000_0000;
				end else if (enc_step) begin
					next_count = enc_up ? count + 32'h0000_0001 : count - 32'h0000_0001;
				end
				hit_lo = enc_step && (next_count == setpoint) && (count != setpoint);
			end
			lic_pkg::MODE_COUNT32: begin
				if (lo_pulse) begin
					next_count = step32(count, lo_up, setpoint);
					hit_lo     = (next_count == setpoint) && (count != setpoint); // see R10
				end
			end
			lic_pkg::MODE_COUNT16: begin
				if (lo_pulse) begin
					next_count[15:0] = step16(count[15:0], lo_up, setpoint[15:0]);
					hit_lo           = (next_count[15:0] == setpoint[15:0]) && (count[15:0] != setpoint[15:0]);
				end
				if (hi_pulse) begin
					next_count[31:16] = step16(count[31:16], hi_up, setpoint[31:16]);
					hit_hi            = (next_count[31:16] == setpoint[31:16]) && (count[31:16] != setpoint[31:16]);
				end
			end
			default: begin
				next_count = count;
			end
		endcase
	end

	// Count register; the source must hold direction steady, see R09
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= '0;
		end else if (ctrl[`CTRL_CLEAR]) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt events
	logic irq4_ev;
	logic irq5_ev;
	logic irq_ok;
	logic [`ST_WIDTH-1:0] events;

	// Inputs 4 and 5 usable in every mode except off; edge chosen per input, see R14
	assign irq_ok  = (mode != lic_pkg::MODE_OFF);
	assign irq4_ev = irq_ok & (ctrl[`CTRL_EDGE4] ? fall[4] : rise[4]);
	assign irq5_ev = irq_ok & (ctrl[`CTRL_EDGE5] ? fall[5] : rise[5]);
	assign events  = {enc_ref && (mode == lic_pkg::MODE_ENCODER), irq5_ev, irq4_ev, hit_hi, hit_lo};

	// Write one clears; a new event in the same cycle wins, see R16
	logic [`ST_WIDTH-1:0] next_status;
	assign next_status = (status & ~(wr_status ? wdata_in[`ST_WIDTH-1:0] : '0)) | events;

	// Sticky flags
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// Level interrupt from a flop; follows flags at once, a mask change one cycle later
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(next_status & mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port: data stands one cycle after the strobe
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (rd_in) begin
			case (addr_in)
				`REG_CTRL:     rdata_out <= ctrl;
				`REG_SETPOINT: rdata_out <= 32'(setpoint);
				`REG_COUNT:    rdata_out <= 32'(count);
				`REG_STATUS:   rdata_out <= {27'h0, status};
				`REG_MASK:     rdata_out <= {27'h0, mask};
				`REG_INPUTS:   rdata_out <= {26'h0, lvl};
				default:       rdata_out <= 32'h0000_0000;
			endcase
		end else begin
			rdata_out <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_up_wrap;
		@(posedge mclk_in) disable iff (rst_in)
		(mode == lic_pkg::MODE_COUNT32 && lo_pulse && lo_up && count == setpoint && !ctrl[`CTRL_CLEAR])
			|=> (count == '0);
	endproperty
	a_up_wrap: assert property (p_up_wrap) else $error("up count did not restart at zero"); // see R11

	property p_down_reload;
		@(posedge mclk_in) disable iff (rst_in)
		(mode == lic_pkg::MODE_COUNT32 && lo_pulse && !lo_up && count == setpoint && !ctrl[`CTRL_CLEAR])
			|=> (count == $past(setpoint));
	endproperty
	a_down_reload: assert property (p_down_reload) else $error("down count did not reload"); // see R12

	property p_hi_wrap;
		@(posedge mclk_in) disable iff (rst_in)
		(mode == lic_pkg::MODE_COUNT16 && hi_pulse && hi_up && count[31:16] == setpoint[31:16] && !ctrl[`CTRL_CLEAR])
			|=> (count[31:16] == 16'h0000);
	endproperty
	a_hi_wrap: assert property (p_hi_wrap) else $error("second counter did not restart at zero"); // see R13

	property p_hit_flag;
		@(posedge mclk_in) disable iff (rst_in)
		hit_lo |=> status[`ST_SETPOINT_LO];
	endproperty
	a_hit_flag: assert property (p_hit_flag) else $error("setpoint flag not set"); // see R10

	property p_ref_gate;
		@(posedge mclk_in) disable iff (rst_in)
		(mode == lic_pkg::MODE_ENCODER && rise[2] && !lvl[3] && !enc_step && !ctrl[`CTRL_CLEAR])
			|=> $stable(count);
	endproperty
	a_ref_gate: assert property (p_ref_gate) else $error("reference acted outside window"); // see R06

	property p_ref_flag;
		@(posedge mclk_in) disable iff (rst_in)
		(mode == lic_pkg::MODE_ENCODER && rise[2] && lvl[3]) |=> status[`ST_REFERENCE];
	endproperty
	a_ref_flag: assert property (p_ref_flag) else $error("reference in window not flagged"); // see R06

	sequence s_edge4;
		mode != lic_pkg::MODE_OFF && rise[4] && !ctrl[`CTRL_EDGE4];
	endsequence
	property p_irq4;
		@(posedge mclk_in) disable iff (rst_in)
		s_edge4 |=> status[`ST_IRQ4] && (!$past(mask[`ST_IRQ4]) || irq_out);
	endproperty
	a_irq4: assert property (p_irq4) else $error("input four edge lost"); // see R14

	property p_irq_level;
		@(posedge mclk_in) disable iff (rst_in)
		irq_out == |(status & $past(mask));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level disagrees with flags"); // see R10

	property p_sticky;
		@(posedge mclk_in) disable iff (rst_in)
		(status[`ST_IRQ5] && !wr_status) |=> status[`ST_IRQ5];
	endproperty
	a_sticky: assert property (p_sticky) else $error("pending flag dropped"); // see R16

	property p_enc_up;
		@(posedge mclk_in) disable iff (rst_in)
		(mode == lic_pkg::MODE_ENCODER && rise[0] && !lvl[1] && !enc_ref && !ctrl[`CTRL_CLEAR])
			|=> (count == $past(count) + 32'h0000_0001);
	endproperty
	a_enc_up: assert property (p_enc_up) else $error("encoder forward step wrong"); // see R03

	property p_enc_fall;
		@(posedge mclk_in) disable iff (rst_in)
		(mode == lic_pkg::MODE_ENCODER && fall[1] && !lvl[0] && !enc_ref && !ctrl[`CTRL_CLEAR])
			|=> (count == $past(count) + 32'h0000_0001);
	endproperty
	a_enc_fall: assert property (p_enc_fall) else $error("encoder falling step wrong"); // see R04
endmodule

/* File: tb/lic_field_source.sv */
/*
 Field-side model: encoder tracks, pulse source and switches on six pins.
 Assumes the bench calls its tasks and shares the block clock.
*/
`timescale 1ns/10ps
`include "lic_defs.svh"
module lic_field_source (
	// Clock
	input  wire logic       mclk_in,
	// Field pins
	output logic      [5:0] pins_out
);
	int phase;

	// Switches open, tracks low at time zero
	initial begin
		pins_out = 6'h00;
		phase = 0;
	end

	////////////////////////////////////////////////////////////////
	// Edge spacing keeps the source at the track rate limit
	task automatic gap();
		repeat (`EDGE_SPACING_CYCLES) @(posedge mclk_in);
	endtask

	// One quadrature edge, A leads B when counting up
	task automatic quad(input bit up);
		@(posedge mclk_in);
		phase = up ? phase + 1 : phase + 3;
		pins_out[0] <= (phase % 4 == 1) || (phase % 4 == 2);
		pins_out[1] <= (phase % 4 >= 2);
		gap();
	endtask

	// Direction settles a full gap before the pulse
	task automatic pulse(input int ch, input bit up);
		@(posedge mclk_in);
		pins_out[2 * ch + 1] <= up;
		gap();
		pins_out[2 * ch] <= 1'b1;
		gap();
		pins_out[2 * ch] <= 1'b0;
		gap();
	endtask

	// Single switch level
	task automatic set(input int idx, input bit val);
		@(posedge mclk_in);
		pins_out[idx] <= val;
		gap();
	endtask

	// All pins back to rest, tracks at phase zero
	task automatic idle();
		@(posedge mclk_in);
		pins_out <= 6'h00;
		phase = 0;
		gap();
	endtask
endmodule

/* File: tb/local_input_counter_encoder_tb.sv */
/*
 Bench for the local input counter: register tasks and mode sequences.
 Assumes the field source model and the defs header.
*/
`timescale 1ns/10ps
`include "lic_defs.svh"
module local_input_counter_encoder_tb;
	logic        mclk_in = 1'b0;
	logic        rst_in  = 1'b1;
	logic [7:0]  addr    = 8'h00;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [31:0] rdata;
	logic        irq;
	logic [5:0]  pins;
	int          num_errors = 0;
	int          cmp_count  = 0;

	// 125 MHz clock
	always #4 mclk_in = ~mclk_in;

	lic_field_source src (.mclk_in(mclk_in), .pins_out(pins));

	local_input_counter_encoder DUT (
		.mclk_in(mclk_in), .rst_in(rst_in),
		.local_in_zero_track_a_pulse_in(pins[0]), .local_in_one_track_b_direction_in(pins[1]),
		.local_in_two_reference_pulse_in(pins[2]), .local_in_three_ref_window_in(pins[3]),
		.local_in_four_irq_in(pins[4]), .local_in_five_irq_in(pins[5]),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .irq_out(irq)
	);

	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge mclk_in);
		num_errors++;
		final_report();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge mclk_in);
		rst_in <= 1'b0;
		// Reset values and an unmapped place
		rd_check(`REG_CTRL, 32'h0);
		rd_check(`REG_STATUS, 32'h0);
		wr_reg(8'h20, 32'hffff_ffff);
		rd_check(8'h20, 32'h0);
		// 32-bit counter up to setpoint, then restart at zero
		wr_reg(`REG_SETPOINT, 32'h3);
		wr_reg(`REG_CTRL, 32'h2);
		repeat (3) src.pulse(0, 1'b1);
		rd_check(`REG_COUNT, 32'h3);
		rd_check(`REG_STATUS, 32'h1);
		check({31'h0, irq}, 32'h0);
		wr_reg(`REG_MASK, 32'h1);
		rd_check(`REG_MASK, 32'h1);
		check({31'h0, irq}, 32'h1);
		src.pulse(0, 1'b1);
		rd_check(`REG_COUNT, 32'h0);
		wr_reg(`REG_STATUS, 32'h1);
		rd_check(`REG_STATUS, 32'h0);
		check({31'h0, irq}, 32'h0);
		// Down to setpoint, then reload
		repeat (2) src.pulse(0, 1'b1);
		wr_reg(`REG_SETPOINT, 32'h1);
		src.pulse(0, 1'b0);
		rd_check(`REG_COUNT, 32'h1);
		rd_check(`REG_STATUS, 32'h1);
		src.pulse(0, 1'b0);
		rd_check(`REG_COUNT, 32'h1);
		// Two 16-bit counters side by side
		wr_reg(`REG_SETPOINT, 32'h0001_0005);
		wr_reg(`REG_CTRL, 32'h23);
		repeat (2) src.pulse(0, 1'b1);
		src.pulse(1, 1'b1);
		rd_check(`REG_COUNT, 32'h0001_0002);
		rd_check(`REG_STATUS, 32'h3);
		src.pulse(1, 1'b1);
		rd_check(`REG_COUNT, 32'h0000_0002);
		// Encoder, fourfold evaluation and gated reference
		src.idle();
		wr_reg(`REG_STATUS, 32'h1f);
		wr_reg(`REG_SETPOINT, 32'h100);
		wr_reg(`REG_CTRL, 32'h21);
		repeat (8) src.quad(1'b1);
		rd_check(`REG_COUNT, 32'h8);
		repeat (3) src.quad(1'b0);
		rd_check(`REG_COUNT, 32'h5);
		src.pulse(1, 1'b0);
		rd_check(`REG_COUNT, 32'h5);
		src.pulse(1, 1'b1);
		rd_check(`REG_COUNT, 32'h0);
		rd_check(`REG_STATUS, 32'h10);
		// Interrupt inputs, rising on four, falling on five
		wr_reg(`REG_STATUS, 32'h1f);
		wr_reg(`REG_CTRL, 32'h14);
		wr_reg(`REG_MASK, 32'hc);
		src.set(4, 1'b1);
		src.set(5, 1'b1);
		rd_check(`REG_INPUTS, 32'h39);
		rd_check(`REG_STATUS, 32'h4);
		check({31'h0, irq}, 32'h1);
		src.set(5, 1'b0);
		rd_check(`REG_STATUS, 32'hc);
		wr_reg(`REG_STATUS, 32'h4);
		rd_check(`REG_STATUS, 32'h8);
		wr_reg(`REG_MASK, 32'h0);
		rd_check(`REG_MASK, 32'h0);
		check({31'h0, irq}, 32'h0);
		final_report();
	end
endmodule
